// file: hdl/sfr_bank.sv
// Behaviour
// - Unassigned bit positions hold no storage
// - Power-up-clear bits forced to listed value unless a flag set coincides
// - POR-type bits forced only by power-on
// - Enable bits at lowest byte addresses
// - Enable one: flash, NMI, oscillator, watchdog
// - Watchdog enable acts only in interval mode
// - Enable two: serial B/A transmit, receive
// - Pin NMI event sets bit four
// - Pin reset sets bit three, power-on clears it, power-up clear keeps it
// - Power-on flag set by supply power-up
// - Oscillator fault sets bit one, resets one
// - Watchdog flag: overflow, key; pin reset clears
// - Flag two: serial B/A transmit, receive
// - Enable blocks system NMI, global cannot
`timescale 1ns/1ns
module sfr_bank (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             power_up_clear,
    input  sfr_pkg::sfr_req_t     req,
    output logic [7:0]            rdata,
    input  wire logic             rst_nmi_pin_n,
    input  wire logic             nmi_pin_mode,
    input  wire logic             wdog_interval_mode,
    input  sfr_pkg::sys_evt_t     evt,
    input  wire logic [3:0]       serial_set,
    input  wire logic             gie,
    output sfr_pkg::irq_t         irq
);
    logic [7:0]         sys_en_r;
    logic [7:0]         ser_en_r;
    logic [7:0]         sys_flg_r;
    logic [7:0]         ser_flg_r;
    logic [7:0]         rdata_r;
    sfr_pkg::irq_t      irq_r;
    logic [7:0]         sys_en_nxt;
    logic [7:0]         ser_en_nxt;
    logic [7:0]         sys_flg_nxt;
    logic [7:0]         ser_flg_nxt;
    logic [7:0]         rdata_nxt;
    sfr_pkg::irq_t      irq_nxt;

    wire                pin_fall;

    pin_sync3 u_pin_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pin_in  (rst_nmi_pin_n),
        .level   (),
        .fall    (pin_fall)
    );

    // Address decode
    wire hit_sys_en  = (req.addr == sfr_pkg::OFS_SYS_EN);
    wire hit_ser_en  = (req.addr == sfr_pkg::OFS_SER_EN);
    wire hit_sys_flg = (req.addr == sfr_pkg::OFS_SYS_FLG);
    wire hit_ser_flg = (req.addr == sfr_pkg::OFS_SER_FLG);
    wire wr_ok       = req.wr_en && !power_up_clear;
    wire wr_sys_en   = wr_ok && hit_sys_en;
    wire wr_ser_en   = wr_ok && hit_ser_en;
    wire wr_sys_flg  = wr_ok && hit_sys_flg;
    wire wr_ser_flg  = wr_ok && hit_ser_flg;

    // Pin events by function of the shared pin, one cycle per fall
    wire pin_edge    = pin_fall;
    wire nmi_evt     = pin_edge && nmi_pin_mode;
    wire ext_rst_evt = pin_edge && !nmi_pin_mode;
    wire wdog_set    = evt.wdog_overflow || evt.key_violation;

    // Enable registers, absent bits never stored
    assign sys_en_nxt = power_up_clear ? sfr_pkg::SYS_EN_RST :
                        wr_sys_en ? (req.wdata & sfr_pkg::SYS_EN_MASK) :
                        sys_en_r;
    assign ser_en_nxt = power_up_clear ? sfr_pkg::SER_EN_RST :
                        wr_ser_en ? (req.wdata & sfr_pkg::SER_EN_MASK) :
                        ser_en_r;

    // First flag register: software value, clears, then sets win
    wire [7:0] sys_flg_sw  = wr_sys_flg ? (req.wdata & sfr_pkg::SYS_FLG_MASK) : sys_flg_r;
    wire [7:0] sys_flg_pwr = power_up_clear ?
                             ((sys_flg_sw & ~sfr_pkg::SYS_FLG_CLR_BITS) | sfr_pkg::SYS_FLG_CLR_VAL) :
                             sys_flg_sw;
    wire [7:0] sys_flg_clr = sfr_pkg::bit_at(sfr_pkg::B_WDOG, ext_rst_evt);
    wire [7:0] sys_flg_set = sfr_pkg::bit_at(sfr_pkg::B_PIN_NMI, nmi_evt)
                           | sfr_pkg::bit_at(sfr_pkg::B_EXT_RST, ext_rst_evt)
                           | sfr_pkg::bit_at(sfr_pkg::B_OSC, evt.osc_fault)
                           | sfr_pkg::bit_at(sfr_pkg::B_WDOG, wdog_set);
    assign sys_flg_nxt = (sys_flg_pwr & ~sys_flg_clr) | sys_flg_set;

    // Serial flags, one slice per bit
    genvar g;
    generate
        for (g = 0; g < sfr_pkg::SERIAL_N; g++) begin : g_serial
            wire sw_v  = wr_ser_flg ? req.wdata[g] : ser_flg_r[g];
            wire pwr_v = power_up_clear ? sfr_pkg::SER_FLG_RST[g] : sw_v;
            assign ser_flg_nxt[g] = pwr_v || serial_set[g];
        end
    endgenerate
    assign ser_flg_nxt[7:sfr_pkg::SERIAL_N] = '0;

    // Readback, absent bits read zero
    assign rdata_nxt = !req.rd_en ? rdata_r :
                       hit_sys_en  ? sys_en_r :
                       hit_ser_en  ? ser_en_r :
                       hit_sys_flg ? sys_flg_r :
                       hit_ser_flg ? ser_flg_r :
                       sfr_pkg::ZERO_BYTE;

    // Requests: flag and enable both set
    wire nmi_src  = (sys_flg_r[sfr_pkg::B_PIN_NMI] && sys_en_r[sfr_pkg::B_PIN_NMI])
                 || (sys_flg_r[sfr_pkg::B_OSC] && sys_en_r[sfr_pkg::B_OSC])
                 || (evt.flash_violation_flag && sys_en_r[sfr_pkg::B_FLASH_VIOL]);
    wire wdog_src = wdog_interval_mode && gie
                 && sys_flg_r[sfr_pkg::B_WDOG] && sys_en_r[sfr_pkg::B_WDOG];
    wire rx_src   = gie && |(ser_flg_r & ser_en_r & sfr_pkg::RX_MASK);
    wire tx_src   = gie && |(ser_flg_r & ser_en_r & sfr_pkg::TX_MASK);

    assign irq_nxt.sys_nmi   = nmi_src;
    assign irq_nxt.wdog      = wdog_src;
    assign irq_nxt.serial_rx = rx_src;
    assign irq_nxt.serial_tx = tx_src;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sys_en_r <= sfr_pkg::SYS_EN_RST;
            ser_en_r <= sfr_pkg::SER_EN_RST;
            sys_flg_r <= sfr_pkg::SYS_FLG_POR;
            ser_flg_r <= sfr_pkg::SER_FLG_RST;
            rdata_r <= sfr_pkg::ZERO_BYTE;
            irq_r <= '0;
        end else begin
            sys_en_r <= sys_en_nxt;
            ser_en_r <= ser_en_nxt;
            sys_flg_r <= sys_flg_nxt;
            ser_flg_r <= ser_flg_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign rdata = rdata_r;
    assign irq   = irq_r;

    // Checks
    chk_absent_bits: assert property (
        @(posedge clk_sys) disable iff (rst)
        ((sys_en_r & ~sfr_pkg::SYS_EN_MASK) == 8'h00)
        && ((ser_en_r & ~sfr_pkg::SER_EN_MASK) == 8'h00)
        && ((sys_flg_r & ~sfr_pkg::SYS_FLG_MASK) == 8'h00) && (ser_flg_r[7:4] == 4'h0))
        else $error("absent bit holds a value");

    chk_pwr_clr_forces: assert property (
        @(posedge clk_sys) disable iff (rst)
        power_up_clear && !evt.osc_fault && (serial_set == 4'h0)
        |=> (sys_en_r == 8'h00) && (ser_en_r == 8'h00) && (ser_flg_r == sfr_pkg::SER_FLG_RST)
            && sys_flg_r[sfr_pkg::B_OSC])
        else $error("power-up clear did not force its bits");

    chk_por_bits_kept: assert property (
        @(posedge clk_sys) disable iff (rst)
        power_up_clear && !ext_rst_evt && !wdog_set
        |=> sys_flg_r[3:2] == $past(sys_flg_r[3:2]) && sys_flg_r[0] == $past(sys_flg_r[0]))
        else $error("power-up clear touched a power-on bit");

    chk_read_map: assert property (
        @(posedge clk_sys) disable iff (rst)
        req.rd_en && hit_sys_en |=> rdata == $past(sys_en_r))
        else $error("read of first enable register wrong");

    chk_enable_write: assert property (
        @(posedge clk_sys) disable iff (rst)
        wr_sys_en |=> sys_en_r == ($past(req.wdata) & sfr_pkg::SYS_EN_MASK))
        else $error("first enable register write lost");

    chk_wdog_gate: assert property (
        @(posedge clk_sys) disable iff (rst)
        !wdog_interval_mode |=> !irq.wdog)
        else $error("watchdog request outside interval mode");

    chk_nmi_flag_set: assert property (
        @(posedge clk_sys) disable iff (rst)
        nmi_evt |=> sys_flg_r[sfr_pkg::B_PIN_NMI])
        else $error("pin NMI event not flagged");

    chk_ext_reset_set: assert property (
        @(posedge clk_sys) disable iff (rst)
        ext_rst_evt && !wdog_set
        |=> sys_flg_r[sfr_pkg::B_EXT_RST] && !sys_flg_r[sfr_pkg::B_WDOG])
        else $error("pin reset not flagged");

    chk_osc_set: assert property (
        @(posedge clk_sys) disable iff (rst)
        evt.osc_fault |=> sys_flg_r[sfr_pkg::B_OSC])
        else $error("oscillator fault not flagged");

    chk_wdog_set: assert property (
        @(posedge clk_sys) disable iff (rst)
        wdog_set |=> sys_flg_r[sfr_pkg::B_WDOG])
        else $error("watchdog event not flagged");

    chk_serial_set: assert property (
        @(posedge clk_sys) disable iff (rst)
        serial_set != 4'h0 |=> (ser_flg_r[3:0] & $past(serial_set)) == $past(serial_set))
        else $error("serial event lost");

    chk_nmi_no_gie: assert property (
        @(posedge clk_sys) disable iff (rst)
        !gie && sys_flg_r[sfr_pkg::B_OSC] && sys_en_r[sfr_pkg::B_OSC] |=> irq.sys_nmi)
        else $error("global enable blocked a system NMI");

    chk_req_needs_both: assert property (
        @(posedge clk_sys) disable iff (rst)
        irq.serial_rx |-> $past((ser_flg_r & ser_en_r & sfr_pkg::RX_MASK) != 8'h00))
        else $error("receive request without flag and enable");
endmodule

// file: hdl/sfr_pkg.sv
package sfr_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int SERIAL_N = 4;

    // Byte offsets inside the lowest special function range
    localparam logic [ADDR_W-1:0] OFS_SYS_EN  = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_SER_EN  = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_SYS_FLG = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_SER_FLG = 4'h3;

    // Bit positions, first enable and first flag register
    localparam int B_FLASH_VIOL = 5;
    localparam int B_PIN_NMI    = 4;
    localparam int B_EXT_RST    = 3;
    localparam int B_POWER_ON   = 2;
    localparam int B_OSC        = 1;
    localparam int B_WDOG       = 0;

    // Bit positions, serial enable and flag register
    localparam int B_SA_RX = 0;
    localparam int B_SA_TX = 1;
    localparam int B_SB_RX = 2;
    localparam int B_SB_TX = 3;

    // Present bits
    localparam logic [DATA_W-1:0] SYS_EN_MASK  = 8'h33;
    localparam logic [DATA_W-1:0] SER_EN_MASK  = 8'h0F;
    localparam logic [DATA_W-1:0] SYS_FLG_MASK = 8'h1F;
    localparam logic [DATA_W-1:0] SER_FLG_MASK = 8'h0F;
    localparam logic [DATA_W-1:0] RX_MASK   = 8'h05;
    localparam logic [DATA_W-1:0] TX_MASK   = 8'h0A;

    // Reset values
    localparam logic [DATA_W-1:0] SYS_EN_RST       = 8'h00;
    localparam logic [DATA_W-1:0] SER_EN_RST       = 8'h00;
    localparam logic [DATA_W-1:0] SYS_FLG_POR      = 8'h06;
    localparam logic [DATA_W-1:0] SYS_FLG_CLR_BITS = 8'h12;
    localparam logic [DATA_W-1:0] SYS_FLG_CLR_VAL  = 8'h02;
    localparam logic [DATA_W-1:0] SER_FLG_RST      = 8'h0A;
    localparam logic [DATA_W-1:0] ZERO_BYTE     = 8'h00;
    localparam logic [DATA_W-1:0] ONE_BIT       = 8'h01;

    typedef struct packed {
        logic flash_violation_flag;
        logic osc_fault;
        logic wdog_overflow;
        logic key_violation;
    } sys_evt_t;

    typedef struct packed {
        logic sys_nmi;
        logic wdog;
        logic serial_rx;
        logic serial_tx;
    } irq_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              wr_en;
        logic              rd_en;
        logic [DATA_W-1:0] wdata;
    } sfr_req_t;

    function automatic logic [DATA_W-1:0] bit_at(input int pos, input logic v);
        bit_at = v ? (ONE_BIT << pos) : ZERO_BYTE;
    endfunction

endpackage

// file: hdl/pin_sync3.sv
`timescale 1ns/1ns
module pin_sync3 (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic pin_in,
    output logic      level,
    output logic      fall
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;
    wire  agree = (s2_r == s3_r);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s1_r    <= 1'b1;
            s2_r    <= 1'b1;
            s3_r    <= 1'b1;
            level_r <= 1'b1;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (agree) begin
                level_r <= s3_r;
            end
        end
    end

    // Change counts once the second and third stages agree
    assign level = level_r;
    assign fall  = agree && level_r && !s3_r;
endmodule

// file: verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic              clk_sys;
    logic              rst;
    logic              power_up_clear;
    sfr_pkg::sfr_req_t req;
    logic [7:0]        rdata;
    logic              rst_nmi_pin_n;
    logic              nmi_pin_mode;
    logic              wdog_interval_mode;
    sfr_pkg::sys_evt_t evt;
    logic [3:0]        serial_set;
    logic              gie;
    sfr_pkg::irq_t     irq;
    int                err_count;
    int                checked;
    int                seed;
    int                cycles = 0;
    logic [7:0]        v [4];
    logic [3:0]        a;
    logic [7:0]        d;
    logic [2:0]        m;

    sfr_bank DUT (
        .clk_sys            (clk_sys),
        .rst                (rst),
        .power_up_clear     (power_up_clear),
        .req                (req),
        .rdata              (rdata),
        .rst_nmi_pin_n      (rst_nmi_pin_n),
        .nmi_pin_mode       (nmi_pin_mode),
        .wdog_interval_mode (wdog_interval_mode),
        .evt                (evt),
        .serial_set         (serial_set),
        .gie                (gie),
        .irq                (irq)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Hang guard
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            wrap_up(1);
        end
    end

    function automatic logic [7:0] mask_of(input logic [3:0] ad);
        case (ad)
            4'h0:    mask_of = sfr_pkg::SYS_EN_MASK;
            4'h1:    mask_of = sfr_pkg::SER_EN_MASK;
            4'h2:    mask_of = sfr_pkg::SYS_FLG_MASK;
            4'h3:    mask_of = sfr_pkg::SER_FLG_MASK;
            default: mask_of = sfr_pkg::ZERO_BYTE;
        endcase
    endfunction

    function automatic logic [3:0] exp_irq(input logic [7:0] e1, e2, f1, f2,
                                           input logic [2:0] mm);
        exp_irq = {(|(e1 & f1 & 8'h12)) | (mm[2] & e1[5]),
                   mm[1] & mm[0] & e1[0] & f1[0],
                   mm[0] & (|(e2 & f2 & sfr_pkg::RX_MASK)),
                   mm[0] & (|(e2 & f2 & sfr_pkg::TX_MASK))};
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] ad, input logic [7:0] dat);
        @(posedge clk_sys);
        req.addr  <= ad;
        req.wdata <= dat;
        req.wr_en <= 1'b1;
        @(posedge clk_sys);
        req.wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] ad, input logic [7:0] exp);
        @(posedge clk_sys);
        req.addr  <= ad;
        req.rd_en <= 1'b1;
        @(posedge clk_sys);
        req.rd_en <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk(rdata, exp);
    endtask

    task automatic pin_pulse();
        @(posedge clk_sys);
        rst_nmi_pin_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_nmi_pin_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
    endtask

    task automatic wrap_up(input int late);
        $display("checks %0d mismatches %0d", checked, err_count + late);
        if (err_count + late == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        seed = 72;
        err_count = 0;
        checked = 0;
        rst = 1'b1;
        power_up_clear = 1'b0;
        req = '0;
        rst_nmi_pin_n = 1'b1;
        nmi_pin_mode = 1'b1;
        wdog_interval_mode = 1'b0;
        evt = '0;
        serial_set = 4'h0;
        gie = 1'b0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        rd(4'h0, 8'h00);
        rd(4'h1, 8'h00);
        rd(4'h2, 8'h06);
        rd(4'h3, 8'h0A);
        rd(4'h9, 8'h00);
        $display("test reset_values done");
        repeat (30) begin
            a = 4'($random(seed));
            d = 8'($random(seed));
            wr(a, d);
            rd(a, d & mask_of(a));
        end
        $display("test random_access done");
        for (int i = 0; i < 4; i++) wr(i[3:0], 8'hFF);
        @(posedge clk_sys);
        power_up_clear <= 1'b1;
        req.addr <= 4'h0;
        req.wdata <= 8'hFF;
        req.wr_en <= 1'b1;
        @(posedge clk_sys);
        power_up_clear <= 1'b0;
        req.wr_en <= 1'b0;
        rd(4'h0, 8'h00);
        rd(4'h1, 8'h00);
        rd(4'h2, 8'h0F);
        rd(4'h3, 8'h0A);
        $display("test power_up_clear done");
        for (int i = 0; i < 3; i++) begin
            wr(4'h2, 8'h00);
            @(posedge clk_sys);
            evt <= sfr_pkg::sys_evt_t'(4'h4 >> i);
            @(posedge clk_sys);
            evt <= '0;
            rd(4'h2, (i == 0) ? 8'h02 : 8'h01);
        end
        for (int i = 0; i < 4; i++) begin
            wr(4'h3, 8'h00);
            @(posedge clk_sys);
            serial_set <= 4'h1 << i;
            @(posedge clk_sys);
            serial_set <= 4'h0;
            rd(4'h3, 8'h01 << i);
        end
        $display("test hw_events done");
        wr(4'h2, 8'h00);
        pin_pulse();
        rd(4'h2, 8'h10);
        nmi_pin_mode <= 1'b0;
        wr(4'h2, 8'h01);
        pin_pulse();
        rd(4'h2, 8'h08);
        nmi_pin_mode <= 1'b1;
        $display("test pin_events done");
        for (int k = 0; k < 40; k++) begin
            for (int i = 0; i < 4; i++) v[i] = 8'($random(seed));
            m = 3'($random(seed));
            if (k == 0) begin
                v = '{8'h11, 8'h0F, 8'h11, 8'h0F};
                m = 3'b010;
            end
            @(posedge clk_sys);
            gie <= m[0];
            wdog_interval_mode <= m[1];
            evt <= sfr_pkg::sys_evt_t'({m[2], 3'b000});
            for (int i = 0; i < 4; i++) wr(i[3:0], v[i]);
            repeat (3) @(posedge clk_sys);
            #1;
            chk({4'h0, irq}, {4'h0, exp_irq(v[0], v[1], v[2], v[3], m)});
        end
        $display("test irq_gating done");
        wrap_up(0);
    end
endmodule
